//--- design/fpiop_pkg.sv
// Constants, types and register map for the four-pin I/O port.
package fpiop_pkg;
	localparam int         PIN_COUNT       = 4;
	localparam int         ADDR_W          = 8;
	localparam int         DATA_W          = 8;
	localparam logic [7:0] ADDR_LATCH      = 8'h00;
	localparam logic [7:0] ADDR_DIR        = 8'h01;
	localparam logic [7:0] ADDR_PULLUP     = 8'h02;
	localparam logic [7:0] ADDR_CTRL       = 8'h03;
	localparam logic [3:0] LATCH_RST       = 4'h0;
	localparam logic [3:0] DIR_RST         = 4'h0;
	localparam logic [3:0] PULLUP_RST      = 4'h0;
	localparam logic [3:0] NIB_ZERO        = 4'h0;
	localparam logic [7:0] BYTE_ZERO       = 8'h00;
	localparam logic [3:0] UPPER_ZERO      = 4'h0;
	localparam logic [3:0] OPEN_DRAIN_MASK = 4'hC;
	localparam logic [3:0] PULLUP_MASK     = 4'h3;
	localparam int         CTRL_SPF_BIT    = 0;
	localparam int         CTRL_CID_BIT    = 1;
	localparam int         CTRL_FLOAT_BIT  = 7;
	localparam logic       SPF_RST         = 1'b0;
	localparam logic       CID_RST         = 1'b0;
	localparam int         CMP_NEG_PIN     = 0;
	localparam int         CMP_POS_PIN     = 1;

	typedef logic [PIN_COUNT-1:0] fpiop_nib_t;

	typedef struct packed {
		logic out;
		logic oe;
		logic pu;
	} fpiop_pad_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
		logic              read_modify_write_read;
	} fpiop_bus_t;

	typedef enum {ST_RUN, ST_HOLD, ST_FLOAT} fpiop_stby_t;
endpackage : fpiop_pkg

//--- design/fpiop_sync.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
module fpiop_sync (
	input  wire logic                 mclk,
	input  wire logic                 rstn,
	input  wire fpiop_pkg::fpiop_nib_t raw,
	output fpiop_pkg::fpiop_nib_t      stable
);
	import fpiop_pkg::*;

	fpiop_nib_t s1_q;
	fpiop_nib_t s2_q;
	fpiop_nib_t s3_q;
	fpiop_nib_t stable_q;
	fpiop_nib_t agree;
	fpiop_nib_t stable_d;

	// Stage one feeds stage two only
	assign agree    = ~(s2_q ^ s3_q);
	assign stable_d = (agree & s3_q) | (~agree & stable_q);
	assign stable   = stable_q;

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			s1_q     <= NIB_ZERO;
			s2_q     <= NIB_ZERO;
			s3_q     <= NIB_ZERO;
			stable_q <= NIB_ZERO;
		end else begin
			s1_q     <= raw;
			s2_q     <= s1_q;
			s3_q     <= s2_q;
			stable_q <= stable_d;
		end
	end
endmodule : fpiop_sync

//--- design/fpiop_pad.sv
// Output drive, open-drain and pull-up control for one pin.
`timescale 1ns/1ps
module fpiop_pad (
	input  wire logic          mclk,
	input  wire logic          rstn,
	input  wire logic          latch,
	input  wire logic          dir,
	input  wire logic          pu_en,
	input  wire logic          periph_oe,
	input  wire logic          periph_out,
	input  wire logic          float_pins,
	input  wire logic          open_drain,
	input  wire logic          pu_capable,
	output fpiop_pkg::fpiop_pad_t pad
);
	import fpiop_pkg::*;

	fpiop_pad_t pad_q;
	fpiop_pad_t pad_d;
	logic       src;
	logic       want_drive;
	logic       od_release;

	assign src        = periph_oe ? periph_out : latch;
	assign want_drive = periph_oe | dir;
	assign od_release = open_drain & src;
	assign pad_d.oe   = want_drive & ~float_pins & ~od_release;
	assign pad_d.out  = pad_d.oe & src;
	// Pull-up never fights a low drive
	assign pad_d.pu   = pu_en & pu_capable & ~(pad_d.oe & ~pad_d.out);
	assign pad        = pad_q;

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			pad_q <= '0;
		end else begin
			pad_q <= pad_d;
		end
	end
endmodule : fpiop_pad

//--- design/fpiop_top.sv
// Four-pin I/O port: registers, standby float, read path and pad control.
`timescale 1ns/1ps
module fpiop_top (
	input  wire logic                  mclk,
	input  wire logic                  rstn,
	input  wire fpiop_pkg::fpiop_bus_t  bus,
	output logic [7:0]                 rdata,
	input  wire fpiop_pkg::fpiop_nib_t  pad_in,
	output fpiop_pkg::fpiop_nib_t       pad_out,
	output fpiop_pkg::fpiop_nib_t       pad_oe,
	output fpiop_pkg::fpiop_nib_t       pad_pullup,
	input  wire fpiop_pkg::fpiop_nib_t  periph_oe,
	input  wire fpiop_pkg::fpiop_nib_t  periph_out,
	output fpiop_pkg::fpiop_nib_t       periph_in,
	input  wire logic                  standby_mode,
	output logic                       pins_floated,
	output logic                       comparator_negative_input_en,
	output logic                       comparator_positive_input_en
);
	import fpiop_pkg::*;

	fpiop_nib_t  port_output_latch_q;
	fpiop_nib_t  port_direction_q;
	fpiop_nib_t  port_pullup_enable_q;
	logic        standby_pin_float_q;
	logic        comparator_input_disable_q;
	fpiop_stby_t stby_q;
	fpiop_stby_t stby_d;
	logic        standby_prev_q;
	logic        pins_floated_q;
	logic        float_next;
	logic [7:0]  rdata_q;
	logic [7:0]  rdata_d;
	fpiop_nib_t  periph_in_q;
	logic        cmp_neg_q;
	logic        cmp_pos_q;
	fpiop_nib_t  pin_level;
	fpiop_nib_t  pin_seen;
	fpiop_nib_t  port_read;
	fpiop_pad_t  pads [PIN_COUNT];
	logic        sel_latch;
	logic        sel_dir;
	logic        sel_pullup;
	logic        sel_ctrl;
	logic        wr_latch;
	logic        wr_dir;
	logic        wr_pullup;
	logic        wr_ctrl;
	logic        standby_entry;
	logic        float_now;
	logic [7:0]  ctrl_view;

	// Per-bit read selection shared by every pin
	function automatic fpiop_nib_t read_select(
		input fpiop_nib_t latch,
		input fpiop_nib_t dir,
		input fpiop_nib_t poe,
		input fpiop_nib_t pin,
		input logic       read_modify_write_read
	);
		fpiop_nib_t gp_out;
		gp_out = dir & ~poe;
		if (read_modify_write_read) begin
			read_select = latch;
		end else begin
			read_select = (gp_out & latch) | (~gp_out & pin);
		end
	endfunction : read_select

	// Address decode
	assign sel_latch  = (bus.addr == ADDR_LATCH);
	assign sel_dir    = (bus.addr == ADDR_DIR);
	assign sel_pullup = (bus.addr == ADDR_PULLUP);
	assign sel_ctrl   = (bus.addr == ADDR_CTRL);
	assign wr_latch   = bus.wr & sel_latch;
	assign wr_dir     = bus.wr & sel_dir;
	assign wr_pullup  = bus.wr & sel_pullup;
	assign wr_ctrl    = bus.wr & sel_ctrl;

	// Float decision is taken once, at standby entry
	assign standby_entry = standby_mode & ~standby_prev_q;
	// Float flag kept in its own flop so the pin comes straight from a register
	assign float_next    = (stby_d == ST_FLOAT);
	assign float_now     = pins_floated_q;

	always_comb begin
		stby_d = stby_q;
		unique case (stby_q)
			ST_RUN: begin
				if (standby_entry) begin
					stby_d = standby_pin_float_q ? ST_FLOAT : ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (!standby_mode) begin
					stby_d = ST_RUN;
				end
			end
			ST_FLOAT: begin
				if (!standby_mode) begin
					stby_d = ST_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			stby_q         <= ST_RUN;
			standby_prev_q <= 1'b0;
			pins_floated_q <= 1'b0;
		end else begin
			stby_q         <= stby_d;
			standby_prev_q <= standby_mode;
			pins_floated_q <= float_next;
		end
	end

	// Registers: only the low nibble exists (only bits 0 and 1 in CTRL), upper bits read zero except CTRL bit 7, which reads the float status
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			port_output_latch_q <= LATCH_RST;
		end else if (wr_latch) begin
			port_output_latch_q <= bus.wdata[PIN_COUNT-1:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			port_direction_q <= DIR_RST;
		end else if (wr_dir) begin
			port_direction_q <= bus.wdata[PIN_COUNT-1:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			port_pullup_enable_q <= PULLUP_RST;
		end else if (wr_pullup) begin
			port_pullup_enable_q <= bus.wdata[PIN_COUNT-1:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			standby_pin_float_q        <= SPF_RST;
			comparator_input_disable_q <= CID_RST;
		end else if (wr_ctrl) begin
			standby_pin_float_q        <= bus.wdata[CTRL_SPF_BIT];
			comparator_input_disable_q <= bus.wdata[CTRL_CID_BIT];
		end
	end

	// Pad level after synchronising
	fpiop_sync u_sync (
		.mclk   (mclk),
		.rstn   (rstn),
		.raw    (pad_in),
		.stable (pin_level)
	);

	// Floated pins present a steady low inward, avoiding open-input leakage
	assign pin_seen = float_now ? NIB_ZERO : pin_level;

	assign port_read = read_select(port_output_latch_q, port_direction_q, periph_oe,
		pin_seen, bus.read_modify_write_read);

	assign ctrl_view = {float_now, 5'h00, comparator_input_disable_q, standby_pin_float_q};

	always_comb begin
		rdata_d = BYTE_ZERO;
		if (bus.rd) begin
			if (sel_latch) begin
				rdata_d = {UPPER_ZERO, port_read};
			end else if (sel_dir) begin
				rdata_d = {UPPER_ZERO, port_direction_q};
			end else if (sel_pullup) begin
				rdata_d = {UPPER_ZERO, port_pullup_enable_q};
			end else if (sel_ctrl) begin
				rdata_d = ctrl_view;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			rdata_q <= BYTE_ZERO;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Peripheral inputs and comparator switches
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			periph_in_q <= NIB_ZERO;
			cmp_neg_q   <= 1'b0;
			cmp_pos_q   <= 1'b0;
		end else begin
			periph_in_q <= pin_seen;
			cmp_neg_q   <= ~comparator_input_disable_q;
			cmp_pos_q   <= ~comparator_input_disable_q;
		end
	end

	// One drive cell per pin
	for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pad
		fpiop_pad u_pad (
			.mclk       (mclk),
			.rstn       (rstn),
			.latch      (port_output_latch_q[i]),
			.dir        (port_direction_q[i]),
			.pu_en      (port_pullup_enable_q[i]),
			.periph_oe  (periph_oe[i]),
			.periph_out (periph_out[i]),
			.float_pins (float_now),
			.open_drain (OPEN_DRAIN_MASK[i]),
			.pu_capable (PULLUP_MASK[i]),
			.pad        (pads[i])
		);
		assign pad_out[i]    = pads[i].out;
		assign pad_oe[i]     = pads[i].oe;
		assign pad_pullup[i] = pads[i].pu;
	end

	assign rdata                        = rdata_q;
	assign periph_in                    = periph_in_q;
	assign pins_floated                 = float_now;
	assign comparator_negative_input_en = cmp_neg_q;
	assign comparator_positive_input_en = cmp_pos_q;
endmodule : fpiop_top

//--- tb/fpiop_pins.sv
// Pin-side model: resolves each pad from device drive, outside drive and pull-up.
`timescale 1ns/1ps
module fpiop_pins (
	input  wire logic                  mclk,
	input  wire fpiop_pkg::fpiop_nib_t pad_out,
	input  wire fpiop_pkg::fpiop_nib_t pad_oe,
	input  wire fpiop_pkg::fpiop_nib_t pad_pullup,
	input  wire fpiop_pkg::fpiop_nib_t ext_val,
	input  wire fpiop_pkg::fpiop_nib_t ext_en,
	output fpiop_pkg::fpiop_nib_t      pad_in
);
	import fpiop_pkg::*;
	fpiop_nib_t float_q = 4'h5;
	// Open pins wander, so the agreement filter never accepts them and their stale level holds
	always_ff @(posedge mclk) begin
		float_q <= ~float_q;
	end
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
		| (~pad_oe & ~ext_en & (pad_pullup | float_q));
endmodule : fpiop_pins

//--- tb/fpiop_props.sv
// Port-level assertions for the four-pin I/O port.
`timescale 1ns/1ps
module fpiop_props (
	input wire logic                  mclk,
	input wire logic                  rstn,
	input wire fpiop_pkg::fpiop_bus_t bus,
	input wire logic [7:0]            rdata,
	input wire fpiop_pkg::fpiop_nib_t pad_out,
	input wire fpiop_pkg::fpiop_nib_t pad_oe,
	input wire fpiop_pkg::fpiop_nib_t pad_pullup,
	input wire fpiop_pkg::fpiop_nib_t periph_oe,
	input wire fpiop_pkg::fpiop_nib_t periph_out,
	input wire fpiop_pkg::fpiop_nib_t periph_in,
	input wire logic                  standby_mode,
	input wire logic                  pins_floated,
	input wire logic                  comparator_negative_input_en,
	input wire logic                  comparator_positive_input_en
);
	import fpiop_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	sequence float_held; pins_floated [*2]; endsequence
	sequence port_read; bus.rd && bus.addr < 8'h03; endsequence
	sequence periph_high; periph_oe[0] && periph_out[0] && !standby_mode && !pins_floated;
	endsequence
	upper_bits_a: assert property (port_read |=> rdata[7:4] == 4'h0)
		else $error("upper read bits set");
	unmapped_read_a: assert property (bus.rd && bus.addr > 8'h03 |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	periph_route_a: assert property (periph_high |=> pad_oe[0] && pad_out[0])
		else $error("peripheral drive not routed");
	float_drive_a: assert property (float_held |-> pad_oe == 4'h0)
		else $error("floated pin still driven");
	float_input_a: assert property (float_held |-> periph_in == 4'h0)
		else $error("floated input not held low");
	float_exit_a: assert property (!standby_mode |=> !pins_floated)
		else $error("float outlives standby");
	pullup_low_a: assert property ((pad_pullup & pad_oe & ~pad_out) == 4'h0)
		else $error("pull-up on low pin");
	open_drain_a: assert property ((pad_oe[3:2] & pad_out[3:2]) == 2'b00)
		else $error("open-drain pin driven high");
	cmp_pair_a: assert property (comparator_negative_input_en ==
		comparator_positive_input_en)
		else $error("comparator enables differ");
	reset_dir_a: assert property ($rose(rstn) |-> pad_oe == 4'h0)
		else $error("pin driven after reset");
endmodule : fpiop_props
bind fpiop_top fpiop_props u_props (.mclk, .rstn, .bus, .rdata, .pad_out, .pad_oe, .pad_pullup,
	.periph_oe, .periph_out, .periph_in, .standby_mode, .pins_floated,
	.comparator_negative_input_en, .comparator_positive_input_en);

//--- tb/fpiop_bench.sv
// Self-checking bench for the four-pin I/O port.
`timescale 1ns/1ps
module fpiop_bench;
	import fpiop_pkg::*;
	logic       mclk;
	logic       rstn;
	fpiop_bus_t bus;
	logic [7:0] rdata;
	fpiop_nib_t pad_in;
	fpiop_nib_t pad_out;
	fpiop_nib_t pad_oe;
	fpiop_nib_t pad_pullup;
	fpiop_nib_t periph_oe;
	fpiop_nib_t periph_out;
	fpiop_nib_t periph_in;
	fpiop_nib_t ext_val;
	fpiop_nib_t ext_en;
	logic       standby_mode;
	logic       pins_floated;
	logic       cmp_n;
	logic       cmp_p;
	int         error_cnt;
	int         check_count;

	fpiop_top DUT (.mclk, .rstn, .bus, .rdata, .pad_in, .pad_out, .pad_oe, .pad_pullup,
		.periph_oe, .periph_out, .periph_in, .standby_mode, .pins_floated,
		.comparator_negative_input_en(cmp_n), .comparator_positive_input_en(cmp_p));
	fpiop_pins PINS (.mclk, .pad_out, .pad_oe, .pad_pullup, .ext_val, .ext_en, .pad_in);

	task automatic end_of_test();
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge mclk);
		bus <= '{a, d, 1'b1, 1'b0, 1'b0};
		@(posedge mclk);
		bus.wr <= 1'b0;
	endtask : wr
	task automatic rd(logic [7:0] a, logic m, logic [7:0] exp, string name);
		@(posedge mclk);
		bus <= '{a, 8'h00, 1'b0, 1'b1, m};
		@(posedge mclk);
		bus.rd <= 1'b0;
		#1;
		chk(name, exp, rdata);
	endtask : rd
	task automatic settle(int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : settle
	task automatic t_output();
		wr(ADDR_DIR, 8'hF3);
		wr(ADDR_LATCH, 8'hF5);
		settle(1);
		chk("oe", 8'h03, {4'h0, pad_oe});
		chk("out", 8'h01, {4'h0, pad_out});
		rd(ADDR_DIR, 1'b0, 8'h03, "dir");
	endtask : t_output
	task automatic t_input();
		ext_en <= 4'hC;
		ext_val <= 4'h8;
		settle(6);
		rd(ADDR_LATCH, 1'b0, 8'h09, "pins");
		chk("per in", 8'h09, {4'h0, periph_in});
		rd(ADDR_LATCH, 1'b1, 8'h05, "rmw");
		ext_en <= 4'h0;
	endtask : t_input
	task automatic t_pins();
		wr(ADDR_DIR, 8'h0C);
		wr(ADDR_LATCH, 8'h04);
		settle(1);
		chk("od oe", 8'h08, {4'h0, pad_oe});
		ext_en <= 4'h7;
		ext_val <= 4'h1;
		settle(4);
		rd(ADDR_LATCH, 1'b0, 8'h05, "od rd");
		ext_en <= 4'h0;
		wr(ADDR_DIR, 8'h00);
		wr(ADDR_PULLUP, 8'h03);
		settle(1);
		chk("pu", 8'h03, {4'h0, pad_pullup});
		rd(ADDR_PULLUP, 1'b0, 8'h03, "pu rd");
		wr(ADDR_DIR, 8'h03);
		wr(ADDR_LATCH, 8'h02);
		settle(1);
		chk("pu low", 8'h02, {4'h0, pad_pullup});
	endtask : t_pins
	task automatic t_periph();
		wr(ADDR_LATCH, 8'h03);
		periph_out <= 4'h0;
		periph_oe <= 4'h1;
		settle(6);
		chk("per out", 8'h02, {4'h0, pad_out});
		rd(ADDR_LATCH, 1'b0, 8'h02, "per rd");
		rd(ADDR_LATCH, 1'b1, 8'h03, "per rmw");
		periph_out <= 4'h1;
		settle(2);
		chk("per hi", 8'h03, {4'h0, pad_out});
		periph_oe <= 4'h0;
		periph_out <= 4'h0;
	endtask : t_periph
	task automatic t_standby(logic [7:0] ctl, logic [7:0] e_oe, logic [7:0] e_fl,
		logic [7:0] e_in);
		wr(ADDR_CTRL, ctl);
		standby_mode <= 1'b1;
		settle(3);
		chk("sb oe", e_oe, {4'h0, pad_oe});
		chk("sb out", e_oe, {4'h0, pad_out});
		chk("sb in", e_in, {4'h0, periph_in});
		chk("floated", e_fl, {7'h00, pins_floated});
		rd(ADDR_CTRL, 1'b0, {e_fl[0], 5'h00, ctl[1:0]}, "ctrl rd");
		standby_mode <= 1'b0;
		settle(2);
	endtask : t_standby
	task automatic t_reset();
		rstn <= 1'b0;
		settle(2);
		rstn <= 1'b1;
		chk("oe rst", 8'h00, {4'h0, pad_oe});
		rd(ADDR_DIR, 1'b0, 8'h00, "dir rst2");
	endtask : t_reset

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		repeat (20000) @(posedge mclk);
		error_cnt++;
		end_of_test();
	end
	initial begin
		rstn = 1'b0;
		bus = '0;
		periph_oe = 4'h0;
		periph_out = 4'h0;
		ext_val = 4'h0;
		ext_en = 4'h0;
		standby_mode = 1'b0;
		repeat (8) @(posedge mclk);
		rstn <= 1'b1;
		rd(ADDR_DIR, 1'b0, 8'h00, "dir rst");
		chk("cmp", 8'h01, {7'h00, cmp_n & cmp_p});
		t_output();
		t_input();
		t_pins();
		t_periph();
		t_standby(8'h01, 8'h00, 8'h01, 8'h00);
		t_standby(8'h00, 8'h03, 8'h00, 8'h03);
		wr(ADDR_CTRL, 8'h02);
		settle(1);
		chk("cmp off", 8'h00, {7'h00, cmp_n | cmp_p});
		rd(8'h10, 1'b0, 8'h00, "unmapped");
		t_reset();
		end_of_test();
	end
endmodule : fpiop_bench
